// ===== logic/rlhm_consts.svh
// register offsets, field positions, reset values and timing counts of the rx link health monitor
// assumes inclusion by the package and the testbench files
`ifndef RLHM_CONSTS_SVH
`define RLHM_CONSTS_SVH
`define RLHM_LANES 4
`define RLHM_ADDR_W 12
`define RLHM_OFF_LINK_FAULT 12'h308
`define RLHM_OFF_CLK_LOCK 12'h321
`define RLHM_OFF_FRM_FLAGS 12'h323
`define RLHM_OFF_FRM_CLEAR 12'h324
`define RLHM_OFF_FULLY_ALIGNED 12'h326
`define RLHM_OFF_FIFO_SEL 12'h330
`define RLHM_OFF_FIFO_FLAGS 12'h331
`define RLHM_OFF_LINK_CFG 12'h332
`define RLHM_OFF_ERR_COUNTS 12'h333
`define RLHM_OFF_IRQ_STATUS 12'h340
`define RLHM_OFF_IRQ_MASK 12'h341
`define RLHM_BIT_LOCAL_FAULT 0
`define RLHM_BIT_FULLY_ALIGNED 0
`define RLHM_BIT_CFG_FAULT_GEN 0
`define RLHM_BIT_CLR 0
`define RLHM_IRQ_FRAME_ERROR_FLAGS 0
`define RLHM_IRQ_ALIGN_LOST 1
`define RLHM_IRQ_LOCAL_FAULT 2
`define RLHM_IRQ_FCS_ERR 3
`define RLHM_IRQ_DEC_ERR 4
`define RLHM_IRQ_W 5
`define RLHM_RST_CFG 32'h0000_0001
`define RLHM_RST_SEL 2'h0
`define RLHM_RST_MASK 5'h00
`define RLHM_RST_PULSE_NS 80
`define RLHM_CLK_NS 10
`define RLHM_RST_PULSE_CYC ((`RLHM_RST_PULSE_NS + `RLHM_CLK_NS - 1) / `RLHM_CLK_NS)
`endif

// ===== logic/rlhm_pkg.sv
// types shared by the rx link health monitor modules
// assumes the constants header sits beside it
`include "rlhm_consts.svh"
package rlhm_pkg;
  // one lane's receive status as delivered by the pcs
  typedef struct packed {
    logic word_lock;
    logic clk_lock;
    logic am_lock;
  } rlhm_lane_t;
  // pma fifo flags of one direction
  typedef struct packed {
    logic full;
    logic empty;
  } rlhm_fifo_t;
  // per-frame error strobes from the mac checker
  typedef struct packed {
    logic fcs_err;
    logic dec_err;
  } rlhm_pkt_err_t;
  typedef enum logic [1:0] {
    RLHM_RX_IDLE = 2'b00,
    RLHM_RX_UP = 2'b01,
    RLHM_RX_LOST = 2'b10
  } rlhm_rx_state_t;
endpackage

// ===== logic/rlhm_reset_pulse.sv
// stretches a one-cycle trigger into a fixed-length reset request
// assumes trigger is synchronous to clk_sys
`timescale 1ns/10ps
module rlhm_reset_pulse
  import rlhm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // trigger and request
  input wire logic trigger,
  output logic request
);
  logic [7:0] count;
  logic [7:0] next_count;
  // retrigger restarts the full length so a flapping link never gets a short reset
  assign next_count = trigger ? 8'(`RLHM_RST_PULSE_CYC) : ((count != 8'h00) ? count - 8'h01 : 8'h00);
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      count <= 8'h00;
    else
      count <= next_count;
  end
  assign request = (count != 8'h00);
endmodule // rlhm_reset_pulse

// ===== logic/rlhm_sticky.sv
// bank of sticky flags, set by hardware, cleared in a cycle where clr is high and set is low
// assumes set and clear are single-cycle, synchronous to clk_sys
`timescale 1ns/10ps
module rlhm_sticky
  import rlhm_pkg::*;
#(
  parameter int W = 4
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // set and clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);
  logic [W-1:0] next_flags;
  // set beats clear so an event in the clearing cycle is not lost
  assign next_flags = (flags & ~clr) | set;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      flags <= '0;
    else
      flags <= next_flags;
  end
endmodule // rlhm_sticky

// ===== logic/rlhm_monitor.sv
// rx link health monitor: status registers, loss-of-signal reaction, interrupt
// assumes all lane and error inputs are synchronous to clk_sys
//
// Summary of operation
// [RULE1] writing one then zero clears frame flags
// [RULE2] frame flags zero means every lane locked
// [RULE3] per-lane recovered clock lock readable
// [RULE4] fifo flags read through select register
// [RULE5] signal loss never touches transmit side
// [RULE6] alignment lock loss drops alignment ready
// [RULE7] fully aligned bit follows alignment ready
// [RULE8] fault generation on: local fault on loss
// [RULE9] link fault bit tracks local fault
// [RULE10] signal loss starts rx soft reset request
// [RULE11] packet errors counted fcs, control as decode
// [RULE12] lane order follows transmitter lane tags
// [RULE13] frame flags sticky until clear sequence
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module rlhm_monitor
  import rlhm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [`RLHM_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // receive lane status
  input wire rlhm_lane_t [`RLHM_LANES-1:0] lane_status,
  input wire logic rx_signal_present,
  // virtual lane tags seen on each physical lane
  input wire logic [`RLHM_LANES-1:0][1:0] lane_tag,
  input wire logic [`RLHM_LANES-1:0][7:0] lane_data,
  // pma fifo flags
  input wire rlhm_fifo_t tx_fifo,
  input wire rlhm_fifo_t rx_fifo,
  // packet error strobes
  input wire rlhm_pkt_err_t pkt_err,
  input wire logic pkt_in_data,
  // transmit path passes through untouched
  input wire logic tx_enable_in,
  output logic tx_enable_out,
  // status outputs
  output logic rx_align_ready,
  output logic local_fault,
  output logic rx_soft_reset_req,
  output logic [`RLHM_LANES-1:0][7:0] reordered_data,
  output logic fcs_error,
  output logic decode_error,
  output logic irq
);
  // register storage
  logic [31:0] cfg;
  logic [1:0] fifo_sel;
  logic frm_clear;
  logic [`RLHM_IRQ_W-1:0] irq_mask;
  logic [15:0] fcs_count;
  logic [15:0] dec_count;
  rlhm_rx_state_t rx_state;
  rlhm_rx_state_t next_rx_state;

  // write decode
  wire wr_cfg = reg_wr && (reg_addr == `RLHM_OFF_LINK_CFG);
  wire wr_sel = reg_wr && (reg_addr == `RLHM_OFF_FIFO_SEL);
  wire wr_clr = reg_wr && (reg_addr == `RLHM_OFF_FRM_CLEAR);
  wire wr_mask = reg_wr && (reg_addr == `RLHM_OFF_IRQ_MASK);
  wire wr_irq = reg_wr && (reg_addr == `RLHM_OFF_IRQ_STATUS);
  wire wr_cnt = reg_wr && (reg_addr == `RLHM_OFF_ERR_COUNTS);

  // lane aggregates
  function automatic logic all_set(input logic [`RLHM_LANES-1:0] v);
    all_set = &v;
  endfunction
  logic [`RLHM_LANES-1:0] word_lock_v;
  logic [`RLHM_LANES-1:0] clk_lock_v;
  logic [`RLHM_LANES-1:0] am_lock_v;
  always_comb
  begin
    for (int i = 0; i < `RLHM_LANES; i++)
    begin
      word_lock_v[i] = lane_status[i].word_lock;
      clk_lock_v[i] = lane_status[i].clk_lock;
      am_lock_v[i] = lane_status[i].am_lock;
    end
  end
  wire aligned_now = all_set(am_lock_v) && rx_signal_present;

  // clear sequence: one written, then zero written; clear fires on the zero
  wire clear_fire = wr_clr && frm_clear && !reg_wdata[`RLHM_BIT_CLR]; // see [RULE1]
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      frm_clear <= 1'b0;
    else if (wr_clr)
      frm_clear <= reg_wdata[`RLHM_BIT_CLR];
  end

  // a lane without word lock flags an error; held until the clear sequence
  logic [`RLHM_LANES-1:0] frm_flags;
  rlhm_sticky #(.W(`RLHM_LANES)) u_frm_flags (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(~word_lock_v), // see [RULE2]
    .clr(clear_fire ? {`RLHM_LANES{1'b1}} : {`RLHM_LANES{1'b0}}), // see [RULE13]
    .flags(frm_flags)
  );

  // loss-of-signal state: only tracks rx; transmit enable is a plain pass-through
  always_comb
  begin
    next_rx_state = rx_state;
    unique case (rx_state)
      RLHM_RX_IDLE: if (aligned_now) next_rx_state = RLHM_RX_UP;
      RLHM_RX_UP: if (!aligned_now) next_rx_state = RLHM_RX_LOST;
      RLHM_RX_LOST: if (aligned_now) next_rx_state = RLHM_RX_UP;
      default: next_rx_state = RLHM_RX_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rx_state <= RLHM_RX_IDLE;
    else
      rx_state <= next_rx_state;
  end
  wire loss_event = (rx_state == RLHM_RX_UP) && !aligned_now;
  assign tx_enable_out = tx_enable_in; // see [RULE5]

  // alignment ready and local fault come from flops; status bits read these same flops
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rx_align_ready <= 1'b0;
      local_fault <= 1'b0;
    end
    else
    begin
      rx_align_ready <= aligned_now; // see [RULE6]
      local_fault <= cfg[`RLHM_BIT_CFG_FAULT_GEN] && (next_rx_state == RLHM_RX_LOST); // see [RULE8]
    end
  end

  rlhm_reset_pulse u_rx_reset (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .trigger(loss_event), // see [RULE10]
    .request(rx_soft_reset_req)
  );

  // reorder: each physical lane carries a tag naming its virtual lane position
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reordered_data <= '0;
    else if (aligned_now)
      for (int i = 0; i < `RLHM_LANES; i++)
        reordered_data[lane_tag[i]] <= lane_data[i]; // see [RULE12]
  end

  // error classification: fcs errors inside packets are fcs; fcs errors outside and all decode strobes are decode
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fcs_error <= 1'b0;
      decode_error <= 1'b0;
    end
    else
    begin
      fcs_error <= pkt_err.fcs_err && pkt_in_data; // see [RULE11]
      decode_error <= pkt_err.dec_err || (pkt_err.fcs_err && !pkt_in_data); // see [RULE11]
    end
  end
  // counters saturate rather than wrap, so a long soak never reads falsely clean
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || wr_cnt)
    begin
      fcs_count <= 16'h0000;
      dec_count <= 16'h0000;
    end
    else
    begin
      if (fcs_error && fcs_count != 16'hffff)
        fcs_count <= fcs_count + 16'h0001;
      if (decode_error && dec_count != 16'hffff)
        dec_count <= dec_count + 16'h0001;
    end
  end

  // software controls
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cfg <= `RLHM_RST_CFG;
      fifo_sel <= `RLHM_RST_SEL;
      irq_mask <= `RLHM_RST_MASK;
    end
    else
    begin
      if (wr_cfg)
        cfg <= reg_wdata;
      if (wr_sel)
        fifo_sel <= reg_wdata[1:0];
      if (wr_mask)
        irq_mask <= reg_wdata[`RLHM_IRQ_W-1:0];
    end
  end

  // fifo flag readout chosen by select: 0 tx, 1 rx, 2 both
  logic [3:0] fifo_view;
  assign fifo_view = (fifo_sel == 2'h0) ? {2'h0, tx_fifo} :
                     (fifo_sel == 2'h1) ? {2'h0, rx_fifo} :
                     (fifo_sel == 2'h2) ? {rx_fifo, tx_fifo} : 4'h0; // see [RULE4]

  // interrupt status
  logic [`RLHM_IRQ_W-1:0] irq_set;
  logic [`RLHM_IRQ_W-1:0] irq_status;
  assign irq_set[`RLHM_IRQ_FRAME_ERROR_FLAGS] = |(~word_lock_v & ~frm_flags);
  assign irq_set[`RLHM_IRQ_ALIGN_LOST] = loss_event;
  assign irq_set[`RLHM_IRQ_LOCAL_FAULT] = local_fault == 1'b0 && cfg[`RLHM_BIT_CFG_FAULT_GEN] && loss_event;
  assign irq_set[`RLHM_IRQ_FCS_ERR] = fcs_error;
  assign irq_set[`RLHM_IRQ_DEC_ERR] = decode_error;
  rlhm_sticky #(.W(`RLHM_IRQ_W)) u_irq_status (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(irq_set),
    .clr(wr_irq ? reg_wdata[`RLHM_IRQ_W-1:0] : {`RLHM_IRQ_W{1'b0}}),
    .flags(irq_status)
  );
  assign irq = |(irq_status & irq_mask);

  // read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  assign rd_mux =
    (reg_addr == `RLHM_OFF_LINK_FAULT) ? {31'h0, local_fault} : // see [RULE9]
    (reg_addr == `RLHM_OFF_CLK_LOCK) ? {{(32-`RLHM_LANES){1'b0}}, clk_lock_v} : // see [RULE3]
    (reg_addr == `RLHM_OFF_FRM_FLAGS) ? {{(32-`RLHM_LANES){1'b0}}, frm_flags} : // see [RULE2]
    (reg_addr == `RLHM_OFF_FRM_CLEAR) ? {31'h0, frm_clear} :
    (reg_addr == `RLHM_OFF_FULLY_ALIGNED) ? {31'h0, rx_align_ready} : // see [RULE7]
    (reg_addr == `RLHM_OFF_FIFO_SEL) ? {30'h0, fifo_sel} :
    (reg_addr == `RLHM_OFF_FIFO_FLAGS) ? {28'h0, fifo_view} :
    (reg_addr == `RLHM_OFF_LINK_CFG) ? cfg :
    (reg_addr == `RLHM_OFF_ERR_COUNTS) ? {dec_count, fcs_count} :
    (reg_addr == `RLHM_OFF_IRQ_STATUS) ? {27'h0, irq_status} :
    (reg_addr == `RLHM_OFF_IRQ_MASK) ? {27'h0, irq_mask} : 32'h0000_0000;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0000_0000;
  end
endmodule // rlhm_monitor

// ===== tb/rlhm_monitor_checker.sv
// port assertions for the rx link health monitor
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/10ps
`include "rlhm_consts.svh"
module rlhm_monitor_checker
  import rlhm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // watched ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire rlhm_lane_t [`RLHM_LANES-1:0] lane_status,
  input wire logic rx_signal_present,
  input wire rlhm_pkt_err_t pkt_err,
  input wire logic pkt_in_data,
  input wire logic tx_enable_in,
  input wire logic tx_enable_out,
  input wire logic rx_align_ready,
  input wire logic local_fault,
  input wire logic rx_soft_reset_req,
  input wire logic fcs_error,
  input wire logic decode_error
);
  logic all_am;
  assign all_am = rx_signal_present & lane_status[0].am_lock & lane_status[1].am_lock
    & lane_status[2].am_lock & lane_status[3].am_lock;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_align_drop: assert property (!all_am |=> !rx_align_ready) else $error("ready without lock");
  chk_reset_start: assert property ($fell(rx_align_ready) |-> rx_soft_reset_req) else $error("no reset request");
  chk_reset_len: assert property ($rose(rx_soft_reset_req) |-> rx_soft_reset_req [*8] ##1 !rx_soft_reset_req)
    else $error("reset request length");
  chk_fault_aligned: assert property (local_fault |-> !rx_align_ready) else $error("fault while ready");
  chk_fault_cause: assert property ($rose(local_fault) |-> $fell(rx_align_ready)) else $error("fault cause");
  chk_tx_pass: assert property (tx_enable_out == tx_enable_in) else $error("tx disturbed");
  chk_fcs_flag: assert property (pkt_err.fcs_err && pkt_in_data |=> fcs_error) else $error("fcs missed");
  chk_ctrl_flag: assert property (pkt_err.fcs_err && !pkt_in_data |=> decode_error && !fcs_error)
    else $error("control error class");
  chk_quiet_flag: assert property (pkt_err == 2'b00 |=> !fcs_error && !decode_error)
    else $error("spurious error");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data stray");
endmodule // rlhm_monitor_checker
bind rlhm_monitor rlhm_monitor_checker rlhm_monitor_checker_inst (.*);

// ===== tb/rlhm_link_partner.sv
// remote link partner: lane status, virtual lane tags and lane data
// assumes the bench steers it from clk_sys edges
`timescale 1ns/10ps
`include "rlhm_consts.svh"
module rlhm_link_partner
  import rlhm_pkg::*;
(
  // clock and control
  input wire logic clk_sys,
  input wire logic sig_ok,
  input wire logic am_ok,
  input wire logic [3:0] word_ok,
  input wire logic [3:0] clk_ok,
  input wire logic [1:0] rot,
  // lane side
  output rlhm_lane_t [`RLHM_LANES-1:0] lane_status,
  output logic rx_signal_present,
  output logic [`RLHM_LANES-1:0][1:0] lane_tag,
  output logic [`RLHM_LANES-1:0][7:0] lane_data
);
  integer seed = 32'h5a17;
  assign rx_signal_present = sig_ok;
  // no word or marker lock survives a dead line; clock lock does
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      lane_status[i] = '{word_ok[i] & sig_ok, clk_ok[i], am_ok & sig_ok};
      lane_tag[i] = 2'(i + rot);
    end
  end
  // fresh data each cycle so a stale capture cannot match by luck
  always @(posedge clk_sys)
    lane_data <= $random(seed);
endmodule // rlhm_link_partner

// ===== tb/tb_top.sv
// bench for the rx link health monitor with a link partner and reference counts
// assumes the checker binds itself to the monitor
`timescale 1ns/10ps
`include "rlhm_consts.svh"
module tb_top
  import rlhm_pkg::*;
;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, tx_enable_in = 0, pkt_in_data = 0, sig_ok = 1, am_ok = 0;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, w;
  logic [3:0] word_ok = 4'hf, clk_ok = 4'hf;
  logic [1:0] rot = '0;
  rlhm_fifo_t tx_fifo = '0, rx_fifo = '0;
  rlhm_pkt_err_t pkt_err = '0;
  rlhm_lane_t [3:0] lane_status;
  logic rx_signal_present, tx_enable_out, rx_align_ready, local_fault, rx_soft_reset_req, fcs_error, decode_error, irq;
  logic [3:0][1:0] lane_tag;
  logic [3:0][7:0] lane_data, reordered_data, cap;
  integer seed = 32'hd23d, failures = 0, num_checks = 0, cyc = 0, nf = 0, nd = 0;
  rlhm_monitor rlhm_monitor_inst (.*);
  rlhm_link_partner rlhm_link_partner_inst (.*);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    tx_enable_in <= 1'($random(seed));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task report_and_stop;
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rc(12'h332, 32'h1);
    rc(12'h3ff, 32'h0);
    wr(12'h324, 32'h1);
    wr(12'h324, 32'h0);
    rc(12'h323, 32'h0);
    @(posedge clk_sys);
    word_ok <= 4'hb;
    @(posedge clk_sys);
    word_ok <= 4'hf;
    rc(12'h323, 32'h4);
    wr(12'h324, 32'h0);
    rc(12'h323, 32'h4);
    // mask resets to zero, so the pending status stays silent until unmasked
    chk(irq, 32'h0);
    wr(12'h341, 32'h1f);
    chk(irq, 32'h1);
    wr(12'h340, 32'h1f);
    chk(irq, 32'h0);
    wr(12'h341, 32'h0);
    wr(12'h324, 32'h1);
    wr(12'h324, 32'h0);
    rc(12'h323, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_sys);
      w = $random(seed);
      clk_ok <= w[3:0];
      tx_fifo <= w[5:4];
      rx_fifo <= w[7:6];
      wr(12'h330, s);
      rc(12'h321, w[3:0]);
      rc(12'h331, s == 0 ? w[5:4] : s == 1 ? w[7:6] : s == 2 ? w[7:4] : 0);
    end
    // first a dead line with fault generation on, then a lost marker with it off
    for (int c = 1; c >= 0; c--)
    begin
      wr(12'h332, c);
      @(posedge clk_sys);
      sig_ok <= 1'b1;
      am_ok <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 chk(rx_align_ready, 32'h1);
      rc(12'h326, 32'h1);
      rc(12'h308, 32'h0);
      @(posedge clk_sys);
      sig_ok <= c == 0;
      am_ok <= c == 1;
      @(posedge clk_sys);
      #1 chk({rx_align_ready, local_fault, rx_soft_reset_req}, {1'b0, c[0], 1'b1});
      chk(tx_enable_out, tx_enable_in);
      rc(12'h308, c);
      rc(12'h326, 32'h0);
      repeat (8) @(posedge clk_sys);
      #1 chk(rx_soft_reset_req, 32'h0);
    end
    @(posedge clk_sys);
    am_ok <= 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      @(posedge clk_sys);
      rot <= r;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      cap = lane_data;
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 4; i++)
        chk(reordered_data[2'(i + r)], cap[i]);
    end
    wr(12'h333, 32'h0);
    repeat (40)
    begin
      @(posedge clk_sys);
      w = $random(seed);
      pkt_err <= w[1:0];
      pkt_in_data <= w[2];
      nf += w[1] & w[2];
      nd += w[0] | (w[1] & !w[2]);
    end
    @(posedge clk_sys);
    pkt_err <= '0;
    rc(12'h333, {nd[15:0], nf[15:0]});
    report_and_stop;
  end
endmodule // tb_top
